// file: shared/rms_pkg.sv
// Shared constants for the module status word block.
package rms_pkg;
   // Word addresses of the status words in the module memory map.
   localparam logic [6:0]  ADDR_DIGITS_LO  = 7'h4E;
   localparam logic [6:0]  ADDR_DIGITS_HI  = 7'h4F;
   localparam logic [6:0]  ADDR_NV_COUNT   = 7'h50;
   localparam logic [6:0]  ADDR_NV_ERRORS  = 7'h51;
   localparam logic [6:0]  ADDR_NV_CONFIRM = 7'h52;
   localparam logic [6:0]  ADDR_OPEN_FLAGS = 7'h53;

   // Bit positions in the controller's output control word.
   localparam int          CTRL_SAVE_BIT   = 3;
   localparam int          CTRL_CLEAR_BIT  = 6;

   // Sensor type digit encodings reported per input point.
   localparam logic [3:0]  TYPE_CU_10      = 4'h1;
   localparam logic [3:0]  TYPE_PT_100     = 4'h2;
   localparam logic [3:0]  TYPE_NI_120     = 4'h3;

   // Values after reset, and the save count step.
   localparam logic [15:0] RST_WORD        = 16'h0000;
   localparam logic [7:0]  RST_FLAGS       = 8'h00;
   localparam logic [5:0]  RST_ERRORS      = 6'h00;
   localparam logic [15:0] COUNT_STEP      = 16'h0001;

   // Save sequencer states, Gray coded along idle, busy, finish.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_BUSY   = 2'b01,
      ST_FINISH = 2'b11
   } rms_state_t;
endpackage

// file: logic/rms_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser for pin inputs. The output only follows once the
// second and third stages agree, so a value caught mid-change is not passed.
module rms_sync3 #(
   parameter int W = 8
) (
   input  wire logic         CLK,
   input  wire logic         RST_B,
   input  wire logic [W-1:0] PIN_IN,
   output logic      [W-1:0] SYNC_OUT
);
   logic [W-1:0] s1_q;  // First stage, read only by the second stage.
   logic [W-1:0] s2_q;  // Second stage.
   logic [W-1:0] s3_q;  // Third stage.

   // Shift the pin value through the three stages.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= PIN_IN;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept the value only when the last two stages agree.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         SYNC_OUT <= '0;
      end else if (s2_q == s3_q) begin
         SYNC_OUT <= s3_q;
      end
   end
endmodule

// file: logic/rms_status_words.sv
`timescale 1ns/1ps
// Contract
// - Two read words hold eight selector digits.
// - Digit codes: 1 copper, 2 platinum, 3 nickel.
// - Count every completed nonvolatile save.
// - Save faults appear in error bits 0-5.
// - Save refused without loaded confirmation value.
// - Open enabled sensor sets its flag bit.
// - Control bit 6 clears the open flags not detected again in that cycle.
// - Control bit 3 saves working configuration.
module rms_status_words #(
   parameter logic [15:0] CONFIRM_VALUE = 16'h5A5A  // Arbitrary key value.
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic [6:0]  ADDR,
   input  wire logic        WR_EN,
   input  wire logic [15:0] WR_DATA,
   output logic      [15:0] RD_DATA,
   input  wire logic [15:0] CTRL_WORD,
   input  wire logic [31:0] SWITCH_DIGITS,
   input  wire logic [7:0]  SENSOR_OPEN,
   input  wire logic [7:0]  POINT_ENABLE,
   output logic             NV_SAVE_REQ,
   input  wire logic        NV_SAVE_DONE,
   input  wire logic [5:0]  NV_SAVE_ERR
);
   logic [31:0]          digits_s;     // Synchronised selector digits.
   logic [7:0]           open_s;       // Synchronised open-sensor levels.
   logic [15:0]          confirm_q;    // Confirmation word held for saves.
   logic [15:0]          count_q;      // Completed save counter.
   logic [5:0]           err_q;        // Fault flags of the last save.
   logic [7:0]           flags_q;      // Sticky open-sensor flags.
   logic [7:0]           set_vec;      // Points reporting open this cycle.
   logic                 save_prev_q;  // Last value of the save bit.
   logic                 save_trig;    // Rising edge of the save bit.
   logic                 clr_req;      // Flag clear request level.
   logic                 key_ok;       // Confirmation value present.
   rms_pkg::rms_state_t  state_q;      // Save sequencer state.
   logic [15:0]          digits_lo;    // Low digit word, for checking.

   // Selector switches are pins, so they go through the synchroniser.
   rms_sync3 #(.W(32)) u_sync_digits (
      .CLK      (CLK),
      .RST_B    (RST_B),
      .PIN_IN   (SWITCH_DIGITS),
      .SYNC_OUT (digits_s)
   );

   // Open-sensor detector levels come from the analog front end pins.
   rms_sync3 #(.W(8)) u_sync_open (
      .CLK      (CLK),
      .RST_B    (RST_B),
      .PIN_IN   (SENSOR_OPEN),
      .SYNC_OUT (open_s)
   );

   // Pack a flag vector into the low bits of a memory map word.
   function automatic logic [15:0] pad8(input logic [7:0] v);
      pad8 = {8'h00, v};
   endfunction

   // Decode of the control word and the confirmation check.
   assign save_trig = CTRL_WORD[rms_pkg::CTRL_SAVE_BIT] & ~save_prev_q;
   assign clr_req   = CTRL_WORD[rms_pkg::CTRL_CLEAR_BIT];
   assign key_ok    = (confirm_q == CONFIRM_VALUE);
   assign set_vec   = open_s & POINT_ENABLE;
   assign digits_lo = digits_s[15:0];

   // The save request is held while the sequencer waits for the store.
   assign NV_SAVE_REQ = (state_q == rms_pkg::ST_BUSY);

   // Remember the save bit so that a held bit starts only one save.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         save_prev_q <= 1'b0;
      end else begin
         save_prev_q <= CTRL_WORD[rms_pkg::CTRL_SAVE_BIT];
      end
   end

   // Writable confirmation word; the key is kept after a save so that
   // software decides when to disarm it by writing another value.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         confirm_q <= rms_pkg::RST_WORD;
      end else if (WR_EN && (ADDR == rms_pkg::ADDR_NV_CONFIRM)) begin
         confirm_q <= WR_DATA;
      end
   end

   // Save sequencer: a trigger without the key is ignored on purpose,
   // which guards the store against stray control word writes.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_q <= rms_pkg::ST_IDLE;
      end else begin
         case (state_q)
            rms_pkg::ST_IDLE: begin
               // Only a confirmed trigger starts the store.
               if (save_trig && key_ok) begin
                  state_q <= rms_pkg::ST_BUSY;
               end
            end
            rms_pkg::ST_BUSY: begin
               // Wait for the store to report completion.
               if (NV_SAVE_DONE) begin
                  state_q <= rms_pkg::ST_FINISH;
               end
            end
            rms_pkg::ST_FINISH: begin
               // One cycle to book the finished save.
               state_q <= rms_pkg::ST_IDLE;
            end
            default: begin
               state_q <= rms_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Count each completed save; the counter wraps rather than sticks.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         count_q <= rms_pkg::RST_WORD;
      end else if (state_q == rms_pkg::ST_FINISH) begin
         count_q <= count_q + rms_pkg::COUNT_STEP;
      end
   end

   // Capture the fault flags reported with the completion of a save.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         err_q <= rms_pkg::RST_ERRORS;
      end else if ((state_q == rms_pkg::ST_BUSY) && NV_SAVE_DONE) begin
         err_q <= NV_SAVE_ERR;
      end
   end

   // Sticky open flags. A detection in the clearing cycle wins, so an
   // open sensor is never hidden by a clear that races it.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         flags_q <= rms_pkg::RST_FLAGS;
      end else if (clr_req) begin
         flags_q <= set_vec;
      end else begin
         flags_q <= flags_q | set_vec;
      end
   end

   // Registered read port with one cycle of latency; unmapped words read 0.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         RD_DATA <= rms_pkg::RST_WORD;
      end else begin
         case (ADDR)
            // Points one to four, lowest nibble first.
            rms_pkg::ADDR_DIGITS_LO:  RD_DATA <= digits_s[15:0];
            // Points five to eight; digits use the codes 1, 2 and 3.
            rms_pkg::ADDR_DIGITS_HI:  RD_DATA <= digits_s[31:16];
            rms_pkg::ADDR_NV_COUNT:   RD_DATA <= count_q;
            rms_pkg::ADDR_NV_ERRORS:  RD_DATA <= {10'h000, err_q};
            rms_pkg::ADDR_NV_CONFIRM: RD_DATA <= confirm_q;
            rms_pkg::ADDR_OPEN_FLAGS: RD_DATA <= pad8(flags_q);
            default:                  RD_DATA <= rms_pkg::RST_WORD;
         endcase
      end
   end

   // Checks, all in the single clock domain.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   chk_count_step: assert property (
      (state_q == rms_pkg::ST_FINISH) |=>
         (count_q == $past(count_q) + rms_pkg::COUNT_STEP))
      else $error("save count did not advance by one");
   chk_count_hold: assert property (
      (state_q != rms_pkg::ST_FINISH) |=> $stable(count_q))
      else $error("save count moved without a save");
   chk_save_refused: assert property (
      (state_q == rms_pkg::ST_IDLE && !key_ok) |=>
         (state_q == rms_pkg::ST_IDLE) && !NV_SAVE_REQ)
      else $error("save started without confirmation");
   chk_save_started: assert property (
      (state_q == rms_pkg::ST_IDLE && save_trig && key_ok) |=>
         NV_SAVE_REQ ##0 (state_q == rms_pkg::ST_BUSY))
      else $error("confirmed save did not start");
   chk_err_capture: assert property (
      (state_q == rms_pkg::ST_BUSY && NV_SAVE_DONE) |=>
         (err_q == $past(NV_SAVE_ERR)) ##1 (state_q == rms_pkg::ST_IDLE))
      else $error("save fault flags not captured");
   chk_flag_set: assert property (
      1'b1 |=> ((flags_q & $past(set_vec)) == $past(set_vec)))
      else $error("open sensor flag not set");
   chk_flag_clear: assert property (
      (clr_req && set_vec == 8'h00) |=> (flags_q == 8'h00) ##1
         (RD_DATA == 16'h0000 || $past(ADDR) != rms_pkg::ADDR_OPEN_FLAGS))
      else $error("open flags not cleared");
   chk_flag_hold: assert property (
      !clr_req |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
      else $error("open flag dropped without clear");
   chk_digit_read: assert property (
      (ADDR == rms_pkg::ADDR_DIGITS_LO) |=> (RD_DATA == $past(digits_lo)))
      else $error("low digit word read wrong");
   chk_confirm_write: assert property (
      (WR_EN && ADDR == rms_pkg::ADDR_NV_CONFIRM) |=>
         (confirm_q == $past(WR_DATA)))
      else $error("confirmation word not written");
   // A detection in the clearing cycle must survive, a started save must
   // hold until the store answers, and disabled points must never flag.
   chk_set_wins: assert property (
      (clr_req && set_vec != 8'h00) |=> (flags_q == $past(set_vec)))
      else $error("open detection lost to a clear");
   chk_req_held: assert property (
      (NV_SAVE_REQ && !NV_SAVE_DONE) |=> NV_SAVE_REQ)
      else $error("save request dropped before completion");
   chk_point_masked: assert property (
      1'b1 |=>
         ((flags_q & ~$past(flags_q) & ~$past(POINT_ENABLE)) == 8'h00))
      else $error("flag set for a disabled point");

   cov_save_done: cover property (
      (state_q == rms_pkg::ST_BUSY) ##1 (state_q == rms_pkg::ST_FINISH));
   cov_save_refused: cover property (
      save_trig && !key_ok && state_q == rms_pkg::ST_IDLE);
   cov_flag_set: cover property ((flags_q == 8'h00) ##1 (flags_q != 8'h00));
   cov_flag_clear: cover property (
      (flags_q != 8'h00) ##1 clr_req ##1 (flags_q == 8'h00));
   cov_set_wins: cover property (clr_req && set_vec != 8'h00);
endmodule

// file: tb/rms_nv_store_model.sv
`timescale 1ns/1ps
// Behavioural nonvolatile store that answers the block's save requests.
module rms_nv_store_model (
   input  wire logic       CLK,
   input  wire logic       RST_B,
   input  wire logic       NV_SAVE_REQ,
   input  wire logic [7:0] LATENCY,
   input  wire logic [5:0] FAULTS,
   output logic            NV_SAVE_DONE,
   output logic      [5:0] NV_SAVE_ERR
);
   logic [7:0] wait_q;    // Cycles spent on the current save.
   logic       served_q;  // Set once the current save was answered.

   // Count the request, pulse done once, then wait for the request to drop.
   // The fault lines toggle outside the done pulse, so a stale read shows.
   always @(posedge CLK) begin
      NV_SAVE_DONE <= 1'b0;
      NV_SAVE_ERR  <= (NV_SAVE_ERR === 6'bx) ? 6'h2A : ~NV_SAVE_ERR;
      if (!RST_B || !NV_SAVE_REQ) begin
         wait_q   <= 8'h00;
         served_q <= 1'b0;
      end else if (!served_q) begin
         wait_q <= wait_q + 8'h01;
         if (wait_q >= LATENCY) begin
            NV_SAVE_DONE <= 1'b1;
            NV_SAVE_ERR  <= FAULTS;
            served_q     <= 1'b1;
         end
      end
   end
endmodule

// file: tb/tb_rtd_module_status_words.sv
`timescale 1ns/1ps
// Self-checking bench: the driver notes expected reads, a monitor checks.
module tb_rtd_module_status_words;
   localparam logic [15:0] KEY = 16'h5A5A;  // Arbitrary confirmation key.
   logic        clk = 1'b0;         // Module clock, 100 ns period.
   logic        rst_b = 1'b0;       // Synchronous reset, active low.
   logic [6:0]  addr = 7'h00;       // Word address.
   logic        wr_en = 1'b0;       // Write strobe.
   logic [15:0] wr_data = 16'h0000; // Write data.
   logic [15:0] rd_data;            // Registered read data.
   logic [15:0] ctrl_word = 16'h0000; // Controller output word.
   logic [31:0] switch_digits = 32'h00000000; // Selector switch pins.
   logic [7:0]  sensor_open = 8'h00;  // Open-sensor detector pins.
   logic [7:0]  point_enable = 8'h00; // Point enables.
   logic        nv_save_req;        // Save in progress.
   logic        nv_save_done;       // Store finished.
   logic [5:0]  nv_save_err;        // Store fault flags.
   logic [7:0]  lat = 8'h00;        // Store answer delay.
   logic [5:0]  faults = 6'h00;     // Faults the store reports.
   logic        rd_req = 1'b0;      // Read launched this cycle.
   logic        rd_d = 1'b0;        // Read data due this cycle.
   logic        sv_pend = 1'b0;     // Save trigger raised this cycle.
   logic        sv_d = 1'b0;        // Save answer due this cycle.
   logic        req_q[$];           // Expected save starts, oldest first.
   logic [15:0] exp_q[$];           // Expected read values, oldest first.
   logic [31:0] seed = 32'h5F4BF87C; // Random state.
   int          bad_count = 0;      // Mismatches seen.
   int          tests_run = 0;      // Comparisons made.
   int          cyc = 0;            // Cycles elapsed.

   rms_status_words #(.CONFIRM_VALUE(KEY)) i_rms_status_words (
      .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WR_EN(wr_en),
      .WR_DATA(wr_data), .RD_DATA(rd_data), .CTRL_WORD(ctrl_word),
      .SWITCH_DIGITS(switch_digits), .SENSOR_OPEN(sensor_open),
      .POINT_ENABLE(point_enable), .NV_SAVE_REQ(nv_save_req),
      .NV_SAVE_DONE(nv_save_done), .NV_SAVE_ERR(nv_save_err));
   rms_nv_store_model i_rms_nv_store_model (
      .CLK(clk), .RST_B(rst_b), .NV_SAVE_REQ(nv_save_req), .LATENCY(lat),
      .FAULTS(faults), .NV_SAVE_DONE(nv_save_done),
      .NV_SAVE_ERR(nv_save_err));

   always #50 clk = ~clk;

   // Advance the xorshift generator.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Compare one result and report a difference at once.
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Compare whether a save request started as expected.
   task automatic chk_req(input logic e, input logic s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH save_req expected %b seen %b", e, s);
      end
   endtask
   // Print the verdict and stop.
   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One word write; the strobe lasts a single cycle.
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_en <= 1'b1;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Launch a read and note what it must return.
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_req <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd_req <= 1'b0;
   endtask
   // Raise the save bit for one cycle and note whether a save must start.
   task automatic save(input logic go);
      @(posedge clk);
      ctrl_word[3] <= 1'b1;
      sv_pend <= 1'b1;
      req_q.push_back(go);
      @(posedge clk);
      ctrl_word[3] <= 1'b0;
      sv_pend <= 1'b0;
      @(negedge clk);
      for (int n = 0; n < 300 && nv_save_req; n++) @(posedge clk);
      tick(2);
   endtask

   // Read data and the save request land one cycle after they were asked.
   always @(posedge clk) begin
      rd_d <= rd_req;
      sv_d <= sv_pend;
      if (rd_d) chk("rd_data", exp_q.pop_front(), rd_data);
      if (sv_d) chk_req(req_q.pop_front(), nv_save_req);
   end
   // A hang is cut short well beyond the expected run length.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      logic [31:0] dig;
      logic [7:0]  en;
      logic [7:0]  op;
      logic [3:0]  codes[3];
      codes = '{rms_pkg::TYPE_CU_10, rms_pkg::TYPE_PT_100,
                rms_pkg::TYPE_NI_120};
      tick(20);
      rst_b <= 1'b1;
      tick(6);
      // Every word reads zero after reset, unmapped neighbours too.
      for (int a = 'h4D; a <= 'h54; a++) rd(a[6:0], 16'h0000);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         for (int k = 0; k < 8; k++) dig[4*k+:4] = codes[seed[2*k+:2] % 3];
         switch_digits <= dig;
         tick(6);
         rd(rms_pkg::ADDR_DIGITS_LO, dig[15:0]);
         rd(rms_pkg::ADDR_DIGITS_HI, dig[31:16]);
      end
      wr(rms_pkg::ADDR_NV_COUNT, 16'hFFFF);
      rd(rms_pkg::ADDR_NV_COUNT, 16'h0000);
      wr(rms_pkg::ADDR_NV_CONFIRM, KEY ^ 16'h0001);
      rd(rms_pkg::ADDR_NV_CONFIRM, KEY ^ 16'h0001);
      save(1'b0);
      rd(rms_pkg::ADDR_NV_COUNT, 16'h0000);
      wr(rms_pkg::ADDR_NV_CONFIRM, KEY);
      for (int j = 0; j < 3; j++) begin
         seed = xs(seed);
         lat <= 8'(7 * j);
         faults <= seed[5:0];
         save(1'b1);
         rd(rms_pkg::ADDR_NV_COUNT, 16'(j + 1));
         rd(rms_pkg::ADDR_NV_ERRORS, {10'h000, seed[5:0]});
      end
      // A reset in mid-run returns the count, faults and key to zero.
      rst_b <= 1'b0;
      tick(4);
      rst_b <= 1'b1;
      tick(6);
      rd(rms_pkg::ADDR_NV_COUNT, 16'h0000);
      rd(rms_pkg::ADDR_NV_ERRORS, 16'h0000);
      rd(rms_pkg::ADDR_NV_CONFIRM, 16'h0000);
      for (int j = 0; j < 3; j++) begin
         seed = xs(seed);
         en = seed[7:0];
         op = seed[15:8];
         point_enable <= en;
         sensor_open <= op;
         tick(7);
         sensor_open <= 8'h00;
         tick(7);
         rd(rms_pkg::ADDR_OPEN_FLAGS, {8'h00, en & op});
         @(posedge clk);
         ctrl_word[6] <= 1'b1;
         @(posedge clk);
         ctrl_word[6] <= 1'b0;
         rd(rms_pkg::ADDR_OPEN_FLAGS, 16'h0000);
      end
      // A point still open during a clear keeps its flag, since set wins.
      seed = xs(seed);
      point_enable <= 8'hFF;
      sensor_open <= seed[7:0] | 8'h01;
      tick(6);
      ctrl_word[6] <= 1'b1;
      tick(1);
      ctrl_word[6] <= 1'b0;
      sensor_open <= 8'h00;
      rd(rms_pkg::ADDR_OPEN_FLAGS, {8'h00, seed[7:0] | 8'h01});
      tick(3);
      end_of_test();
   end
endmodule
